//--- core/pmss_status_bank.sv
// summary status word and output voltage / current status registers
//
// Overview of operation
// - 16-bit summary word resets to zero; low byte equals status byte.
// - bit 15 is live: any output-voltage status bit active.
// - bit 14 is live: any output-current status bit active.
// - bit 13 is live: any input status bit active.
// - bit 12 is live: any vendor-specific status bit active.
// - bit 11 is live: power-good sense below threshold.
// - bit 8 latches on a pass transistor fault.
// - bits 6,4,3,2,1,0 mirror the status byte bits.
// - reserved bits of all three registers read as zero.
// - voltage register resets to zero; bit 6 latches output overvoltage.
// - voltage register bit 5 latches output undervoltage.
// - current register resets zero; bit 7 latches timed overcurrent shutdown.
// - current register bit 5 latches overcurrent above warning threshold.
// - status byte bit 1 latches on bad command, PEC or message.
// - status byte bit 6 is live: gate drive off.
`timescale 1ns/10ps
`include "pmss_params.svh"
module pmss_status_bank (
  input  wire logic                    mclk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    power_not_good_i,
  input  wire logic                    gate_drive_off_i,
  input  wire logic                    temp_group_pending_i,
  input  wire logic                    input_group_pending_i,
  input  wire logic                    vendor_group_pending_i,
  input  wire logic                    other_status_pending_i,
  input  wire logic                    pass_transistor_fault_i,
  input  wire logic                    overcurrent_shutdown_i,
  input  wire logic                    input_undervolt_i,
  input  wire logic                    output_overvolt_i,
  input  wire logic                    output_undervolt_i,
  input  wire logic                    output_overcurrent_i,
  input  wire pmss_pkg::pmss_comm_err_e comm_err_i,
  input  wire logic                    clear_faults_i,
  input  wire logic [7:0]              rd_addr_i,
  input  wire logic                    rd_en_i,
  output logic [15:0]                  rd_data_o,
  output logic                         rd_hit_o,
  output logic [15:0]                  summary_status_word_o,
  output logic [7:0]                   output_voltage_status_o,
  output logic [7:0]                   output_current_status_o
);
  localparam int NLATCH = 6;

  // latched sources: 0 fet, 1 oc shutdown, 2 input uv, 3 comm, 4 out ov, 5 out uv, 6 oc warn
  logic [NLATCH:0] lat_set;
  logic [NLATCH:0] lat_flag;

  pmss_pkg::pmss_byte_t status_byte;
  pmss_pkg::pmss_byte_t vout_d;
  pmss_pkg::pmss_byte_t iout_d;
  pmss_pkg::pmss_word_t word_d;

  pmss_pkg::pmss_word_t word_q;
  pmss_pkg::pmss_byte_t vout_q;
  pmss_pkg::pmss_byte_t iout_q;
  logic [15:0]          rd_data_q;
  logic                 rd_hit_q;

  always_comb begin
    lat_set[0] = pass_transistor_fault_i;
    lat_set[1] = overcurrent_shutdown_i;
    lat_set[2] = input_undervolt_i;
    lat_set[3] = (comm_err_i != pmss_pkg::PMSS_COMM_NONE);
    lat_set[4] = output_overvolt_i;
    lat_set[5] = output_undervolt_i;
    lat_set[6] = output_overcurrent_i;
  end

  // set beats a simultaneous clear-faults so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi <= NLATCH; gi++) begin : g_latch
      pmss_sticky_bit u_bit (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .set_i   (lat_set[gi]),
        .clear_i (clear_faults_i),
        .flag_o  (lat_flag[gi])
      );
    end
  endgenerate

  always_comb begin
    vout_d = `PMSS_RST_BYTE;
    vout_d[`PMSS_V_OV_WARN] = lat_flag[4];
    vout_d[`PMSS_V_UV_WARN] = lat_flag[5];
    iout_d = `PMSS_RST_BYTE;
    iout_d[`PMSS_I_OC_FAULT] = lat_flag[1];
    iout_d[`PMSS_I_OC_WARN] = lat_flag[6];
  end

  always_comb begin
    status_byte = `PMSS_RST_BYTE;
    status_byte[`PMSS_B_GATE_OFF] = gate_drive_off_i;
    status_byte[`PMSS_B_OC_SHUTDOWN] = lat_flag[1];
    status_byte[`PMSS_B_IN_UV_FAULT] = lat_flag[2];
    status_byte[`PMSS_B_TEMP] = temp_group_pending_i;
    status_byte[`PMSS_B_COMM_ERR] = lat_flag[3];
    status_byte[`PMSS_B_OTHER] = other_status_pending_i;
  end

  always_comb begin
    word_d = {8'h00, status_byte};
    word_d[`PMSS_W_VOUT_GROUP] = |vout_d;
    word_d[`PMSS_W_IOUT_GROUP] = |iout_d;
    word_d[`PMSS_W_INPUT_GROUP] = input_group_pending_i;
    word_d[`PMSS_W_VENDOR_GROUP] = vendor_group_pending_i;
    word_d[`PMSS_W_PWR_NOT_GOOD] = power_not_good_i;
    word_d[`PMSS_W_PASS_FET_FAULT] = lat_flag[0];
  end

  // registered copies keep every output straight from a flip-flop
  // at the cost of one cycle of latency on live bits
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      word_q <= `PMSS_RST_WORD;
      vout_q <= `PMSS_RST_BYTE;
      iout_q <= `PMSS_RST_BYTE;
    end else begin
      word_q <= word_d;
      vout_q <= vout_d;
      iout_q <= iout_d;
    end
  end

  // read port only; no write path exists so host writes have no effect
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rd_data_q <= `PMSS_RST_WORD;
      rd_hit_q  <= 1'b0;
    end else if (rd_en_i) begin
      unique case (rd_addr_i)
        `PMSS_OFS_STATUS_BYTE: begin
          rd_data_q <= {8'h00, word_q[7:0]};
          rd_hit_q  <= 1'b1;
        end
        `PMSS_OFS_SUMMARY_WORD: begin
          rd_data_q <= word_q;
          rd_hit_q  <= 1'b1;
        end
        `PMSS_OFS_VOUT_STATUS: begin
          rd_data_q <= {8'h00, vout_q};
          rd_hit_q  <= 1'b1;
        end
        `PMSS_OFS_CURRENT_GROUP_PENDING: begin
          rd_data_q <= {8'h00, iout_q};
          rd_hit_q  <= 1'b1;
        end
        default: begin
          rd_data_q <= `PMSS_RST_WORD;
          rd_hit_q  <= 1'b0;
        end
      endcase
    end else begin
      rd_hit_q <= 1'b0;
    end
  end

  assign rd_data_o               = rd_data_q;
  assign rd_hit_o                = rd_hit_q;
  assign summary_status_word_o   = word_q;
  assign output_voltage_status_o = vout_q;
  assign output_current_status_o = iout_q;
endmodule

//--- include/pmss_params.svh
// register offsets, field positions and reset values for the status summary bank
`ifndef PMSS_PARAMS_SVH
`define PMSS_PARAMS_SVH

`define PMSS_OFS_STATUS_BYTE   8'h78
`define PMSS_OFS_SUMMARY_WORD  8'h79
`define PMSS_OFS_VOUT_STATUS   8'h7A
`define PMSS_OFS_CURRENT_GROUP_PENDING   8'h7B

`define PMSS_RST_WORD          16'h0000
`define PMSS_RST_BYTE          8'h00

`define PMSS_W_VOUT_GROUP      15
`define PMSS_W_IOUT_GROUP      14
`define PMSS_W_INPUT_GROUP     13
`define PMSS_W_VENDOR_GROUP    12
`define PMSS_W_PWR_NOT_GOOD    11
`define PMSS_W_PASS_FET_FAULT  8

`define PMSS_B_GATE_OFF        6
`define PMSS_B_OC_SHUTDOWN     4
`define PMSS_B_IN_UV_FAULT     3
`define PMSS_B_TEMP            2
`define PMSS_B_COMM_ERR        1
`define PMSS_B_OTHER           0

`define PMSS_V_OV_WARN         6
`define PMSS_V_UV_WARN         5
`define PMSS_I_OC_FAULT        7
`define PMSS_I_OC_WARN         5

`endif

//--- include/pmss_pkg.sv
// types shared by the status summary bank
package pmss_pkg;
  typedef logic [7:0]  pmss_byte_t;
  typedef logic [15:0] pmss_word_t;
  typedef enum logic [1:0] {
    PMSS_COMM_NONE     = 2'b00,
    PMSS_COMM_BAD_CMD  = 2'b01,
    PMSS_COMM_BAD_PEC  = 2'b11,
    PMSS_COMM_BAD_FORM = 2'b10
  } pmss_comm_err_e;
endpackage

//--- core/pmss_sticky_bit.sv
// one latched status flag: set wins over clear
`timescale 1ns/10ps
module pmss_sticky_bit (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic set_i,
  input  wire logic clear_i,
  output logic      flag_o
);
  logic flag_q;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      flag_q <= 1'b0;
    end else if (set_i) begin
      flag_q <= 1'b1;
    end else if (clear_i) begin
      flag_q <= 1'b0;
    end
  end

  assign flag_o = flag_q;
endmodule

//--- sim/pmss_status_bank_props.sv
// port-level checks on the status summary bank
`timescale 1ns/10ps
module pmss_status_bank_props (
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        power_not_good_i,
  input wire logic        pass_transistor_fault_i,
  input wire logic        output_overvolt_i,
  input wire logic        clear_faults_i,
  input wire logic [7:0]  rd_addr_i,
  input wire logic        rd_en_i,
  input wire logic [15:0] rd_data_o,
  input wire logic        rd_hit_o,
  input wire logic [15:0] summary_status_word_o,
  input wire logic [7:0]  output_voltage_status_o,
  input wire logic [7:0]  output_current_status_o
);
  wire [15:0] w = summary_status_word_o;
  wire [7:0]  v = output_voltage_status_o;
  wire [7:0]  c = output_current_status_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_rsvd_zero: assert property ((w & 16'h06a0) == 0 && (v & 8'h9f) == 0
    && (c & 8'h5f) == 0) else $error("reserved bit set");
  a_pgood_live: assert property ($past(rst_n_i) |-> w[11] == $past(power_not_good_i))
    else $error("bit 11 not live");
  a_group_sum: assert property (w[15] == |v && w[14] == |c && w[4] == c[7])
    else $error("group summary wrong");
  a_fet_set: assert property (pass_transistor_fault_i |-> ##2 w[8]) else $error("bit 8");
  a_ov_set: assert property (output_overvolt_i |-> ##2 v[6]) else $error("ov bit");
  // the word lags the sticky flag by one cycle, so a clear shows two edges later
  a_latch_hold: assert property (w[8] && !clear_faults_i && !$past(clear_faults_i)
    |=> w[8]) else $error("lost");
  a_clear_drop: assert property (clear_faults_i && !pass_transistor_fault_i |-> ##2 !w[8])
    else $error("not cleared");
  a_read_hit: assert property (rd_en_i && rd_addr_i[7:2] == 6'h1e |=> rd_hit_o)
    else $error("no hit");
  a_read_miss: assert property (rd_en_i && rd_addr_i[7:2] != 6'h1e |=> !rd_hit_o
    && rd_data_o == 0) else $error("unmapped hit");
endmodule
bind pmss_status_bank pmss_status_bank_props i_props (.*);

//--- sim/pmss_host_model.sv
// bus host model that issues register reads
`timescale 1ns/10ps
module pmss_host_model (
  input  wire logic        mclk_i,
  input  wire logic [15:0] rd_data_i,
  input  wire logic        rd_hit_i,
  output logic             rd_en_o,
  output logic [7:0]       rd_addr_o
);
  initial {rd_en_o, rd_addr_o} = 9'h0;
  // whole word in one read; address inverted after so a stale value never looks valid
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic h);
    @(negedge mclk_i);
    {rd_en_o, rd_addr_o} = {1'b1, a};
    @(negedge mclk_i);
    {rd_en_o, rd_addr_o} = {1'b0, ~a};
    {d, h} = {rd_data_i, rd_hit_i};
  endtask
endmodule

//--- sim/tb.sv
// self-checking bench for the status summary bank
`timescale 1ns/10ps
module tb;
  logic                     mclk_i = 1'b0;
  logic                     rst_n_i = 1'b0;
  logic [12:0]              ev = 13'h0;
  pmss_pkg::pmss_comm_err_e comm = pmss_pkg::PMSS_COMM_NONE;
  logic [15:0]              rd_data;
  logic [7:0]               rd_addr;
  logic                     rd_en, rd_hit;
  logic [15:0]              sw;
  logic [7:0]               vs;
  logic [7:0]               cs;
  int                       n_fail = 0;
  int                       checks = 0;
  localparam int LB [6] = '{11, 6, 2, 13, 12, 0};
  localparam logic [15:0] EW [9] = '{16'h0100, 16'h4010, 16'h8, 16'h8000, 16'h8000,
    16'h4000, 16'h2, 16'h2, 16'h2};
  // voltage byte above current byte
  localparam logic [15:0] EVI [9] = '{16'h0, 16'h80, 16'h0, 16'h4000, 16'h2000,
    16'h20, 16'h0, 16'h0, 16'h0};
  initial forever #20 mclk_i = ~mclk_i;
  pmss_status_bank i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .power_not_good_i(ev[0]),
    .gate_drive_off_i(ev[1]), .temp_group_pending_i(ev[2]), .input_group_pending_i(ev[3]),
    .vendor_group_pending_i(ev[4]), .other_status_pending_i(ev[5]),
    .pass_transistor_fault_i(ev[6]), .overcurrent_shutdown_i(ev[7]),
    .input_undervolt_i(ev[8]), .output_overvolt_i(ev[9]), .output_undervolt_i(ev[10]),
    .output_overcurrent_i(ev[11]), .clear_faults_i(ev[12]), .comm_err_i(comm),
    .rd_addr_i(rd_addr), .rd_en_i(rd_en), .rd_data_o(rd_data), .rd_hit_o(rd_hit),
    .summary_status_word_o(sw), .output_voltage_status_o(vs), .output_current_status_o(cs));
  pmss_host_model i_host (.mclk_i(mclk_i), .rd_data_i(rd_data), .rd_hit_i(rd_hit),
    .rd_en_o(rd_en), .rd_addr_o(rd_addr));
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e, input logic hit);
    logic [15:0] d;
    logic        h;
    i_host.rd(a, d, h);
    checks++;
    if ({h, d} !== {hit, e}) begin
      n_fail++;
      $display("Error read %h expected %h seen %h", a, {hit, e}, {h, d});
    end
  endtask
  // direct register outputs: word, then voltage byte above current byte
  task automatic outchk(input logic [15:0] ew, input logic [15:0] evi);
    checks++;
    if ({sw, vs, cs} !== {ew, evi}) begin
      n_fail++;
      $display("Error outputs expected %h seen %h", {ew, evi}, {sw, vs, cs});
    end
  endtask
  task automatic t_reset();
    rdchk(8'h79, 16'h0, 1'b1);
    rdchk(8'h7a, 16'h0, 1'b1);
    rdchk(8'h7b, 16'h0, 1'b1);
    rdchk(8'h7c, 16'h0, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_live();
    for (int k = 0; k < 6; k++) begin
      @(negedge mclk_i);
      ev[k] = 1'b1;
      repeat (2) @(negedge mclk_i);
      rdchk(8'h79, 16'h1 << LB[k], 1'b1);
      rdchk(8'h78, (16'h1 << LB[k]) & 16'h00ff, 1'b1);
      outchk(16'h1 << LB[k], 16'h0);
      ev[k] = 1'b0;
      repeat (2) @(negedge mclk_i);
      rdchk(8'h79, 16'h0, 1'b1);
    end
    $display("test live done");
  endtask
  task automatic t_latch();
    for (int k = 0; k < 9; k++) begin
      @(negedge mclk_i);
      if (k < 6) ev[6 + k] = 1'b1;
      else comm = pmss_pkg::pmss_comm_err_e'(k - 5);
      @(negedge mclk_i);
      ev[11:6] = 6'h0;
      comm = pmss_pkg::PMSS_COMM_NONE;
      repeat (4) @(negedge mclk_i);
      rdchk(8'h79, EW[k], 1'b1);
      rdchk(8'h7a, {8'h0, EVI[k][15:8]}, 1'b1);
      rdchk(8'h7b, {8'h0, EVI[k][7:0]}, 1'b1);
      outchk(EW[k], EVI[k]);
      ev[12] = 1'b1;
      @(negedge mclk_i);
      ev[12] = 1'b0;
      rdchk(8'h79, 16'h0, 1'b1);
      outchk(16'h0, 16'h0);
    end
    $display("test latch done");
  endtask
  // latch three flags, then reset in mid-run must wipe them
  task automatic t_rst_mid();
    @(negedge mclk_i);
    {ev[9], ev[7], ev[6]} = 3'b111;
    @(negedge mclk_i);
    {ev[9], ev[7], ev[6]} = 3'b000;
    repeat (3) @(negedge mclk_i);
    outchk(16'hc110, 16'h4080);
    rst_n_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    outchk(16'h0, 16'h0);
    rst_n_i = 1'b1;
    rdchk(8'h79, 16'h0, 1'b1);
    rdchk(8'h7a, 16'h0, 1'b1);
    rdchk(8'h7b, 16'h0, 1'b1);
    $display("test mid-run reset done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge mclk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_live();
    t_latch();
    t_rst_mid();
    give_verdict();
  end
  // run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk_i);
    n_fail++;
    give_verdict();
  end
endmodule
